// [verilog/tgc_pkg.sv]
// Shared constants and carrier types for the timer gate control block
package tgc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int TGC_ADDR_W = 5;
  localparam int TGC_DATA_W = 32;
  localparam int TGC_BE_W   = 4;

  // Register byte offsets
  localparam logic [TGC_ADDR_W-1:0] TGC_OFF_GATE_CTRL    = 5'h00;
  localparam logic [TGC_ADDR_W-1:0] TGC_OFF_PERIOD_MATCH = 5'h04;
  localparam logic [TGC_ADDR_W-1:0] TGC_OFF_PERIOD_COUNT = 5'h08;
  localparam logic [TGC_ADDR_W-1:0] TGC_OFF_TIMER_COUNT  = 5'h0C;
  localparam logic [TGC_ADDR_W-1:0] TGC_OFF_COMP_STATUS  = 5'h10;
  localparam logic [TGC_ADDR_W-1:0] TGC_OFF_IRQ_STATUS   = 5'h14;
  localparam logic [TGC_ADDR_W-1:0] TGC_OFF_IRQ_CLEAR    = 5'h18;
  localparam logic [TGC_ADDR_W-1:0] TGC_OFF_IRQ_ENABLE   = 5'h1C;

  // Field positions
  localparam int TGC_SSS_LSB   = 0;
  localparam int TGC_GVAL_BIT  = 2;
  localparam int TGC_POL_BIT   = 6;
  localparam int TGC_GE_BIT    = 7;
  localparam int TGC_RUN_BIT   = 8;
  localparam int TGC_PRUN_BIT  = 9;
  localparam int TGC_CMP1_BIT  = 5;
  localparam int TGC_CMP2_BIT  = 6;
  localparam int TGC_GIF_BIT   = 0;

  // Gate source encodings
  localparam logic [1:0] TGC_SRC_PIN    = 2'h0;
  localparam logic [1:0] TGC_SRC_PERIOD = 2'h1;
  localparam logic [1:0] TGC_SRC_CMP1   = 2'h2;
  localparam logic [1:0] TGC_SRC_CMP2   = 2'h3;

  // Values after reset
  localparam logic [7:0]  TGC_PERIOD_MATCH_RST = 8'hFF;
  localparam logic [7:0]  TGC_PERIOD_COUNT_RST = 8'h00;
  localparam logic [15:0] TGC_TIMER_RST        = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic       period_run;
    logic       timer_run;
    logic       gate_enable_bit;
    logic       gate_polarity_select;
    logic [1:0] gate_source_select;
  } tgc_ctrl_type;

  typedef struct packed {
    logic                  read;
    logic                  write;
    logic [TGC_ADDR_W-1:0] address;
    logic [TGC_DATA_W-1:0] writedata;
    logic [TGC_BE_W-1:0]   byteenable;
  } tgc_avs_req_type;

  typedef struct packed {
    logic gate_pin;
    logic comparator_one_output;
    logic comparator_two_output;
  } tgc_gate_src_type;

endpackage : tgc_pkg

// [verilog/tgc_period_timer.sv]
// Period timer that reloads after a match and emits a one-cycle pulse
`timescale 1ns/100ps
module tgc_period_timer #(
  parameter int PW = 8
) (
  // Clock and reset
  input  wire logic          sys_clk_in,
  input  wire logic          rst_n_in,
  // Control
  input  wire logic          run_in,
  input  wire logic [PW-1:0] period_match_value_in,
  // Status
  output logic      [PW-1:0] period_timer_count_out,
  output logic               match_pulse_out
);
  import tgc_pkg::*;

  typedef struct packed {
    logic [PW-1:0] count;
    logic          pulse;
  } tgc_pt_state_type;

  tgc_pt_state_type st;
  tgc_pt_state_type next_st;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st       = st;
    next_st.pulse = 1'b0;
    if (run_in) begin
      if (st.count == period_match_value_in) begin
        next_st.count = PW'(TGC_PERIOD_COUNT_RST);
        next_st.pulse = 1'b1;
      end else begin
        next_st.count = PW'(st.count + 1'b1);
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st.count <= PW'(TGC_PERIOD_COUNT_RST);
      st.pulse <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign period_timer_count_out = st.count;
  assign match_pulse_out        = st.pulse;

  ////////////////////////////////////////////////////////////////////////////
  chk_reload_to_zero: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (run_in && st.count == period_match_value_in) |=> (st.count == '0))
    else $error("period count did not reload to zero after match");

  chk_pulse_after_reload: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    st.pulse |-> ($past(run_in) && st.count == '0
                  && $past(st.count) == $past(period_match_value_in)))
    else $error("match pulse without a preceding reload");

  chk_pulse_one_cycle: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (st.pulse && period_match_value_in != '0) |=> !st.pulse)
    else $error("match pulse stayed high more than one cycle");

  cov_reload: cover property (
    @(posedge sys_clk_in) disable iff (!rst_n_in) $rose(st.pulse));

endmodule : tgc_period_timer

// [verilog/tgc_top.sv]
// Timer gate control: gate source select, gated timer, event interrupt
//
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps

// Function
// - Period count reloads to zero after match
// - Reload gives one-cycle high gate pulse
// - Polarity one: count only cycle after match
// - Polarity zero: count except cycle after match
// - Comparator one output drives gate
// - Comparator two output drives gate
// - Gate level readable at control bit two
// - Gate level valid with gating disabled
// - Gate level falling edge sets event flag
// - Enabled event flag raises interrupt request
// - Event flag sets with gating disabled
// - Two-bit field selects one of four sources
// - Polarity bit six selects true or inverted
module tgc_top #(
  parameter int TW = 16,
  parameter int PW = 8
) (
  // Clock and reset
  input  wire logic                       sys_clk_in,
  input  wire logic                       rst_n_in,
  // Avalon-MM slave
  input  wire tgc_pkg::tgc_avs_req_type   avs_req_in,
  output logic [tgc_pkg::TGC_DATA_W-1:0]  avs_readdata_out,
  output logic                            avs_waitrequest_out,
  // Gate sources
  input  wire tgc_pkg::tgc_gate_src_type  gate_src_in,
  // Status and interrupt
  output logic                            gate_level_out,
  output logic                            irq_out
);
  import tgc_pkg::*;

  typedef struct packed {
    tgc_ctrl_type          ctrl;
    logic [PW-1:0]         period_match_value;
    logic [TW-1:0]         timer_count;
    logic                  gate_level_status;
    logic                  gate_event_flag;
    logic                  gate_event_irq_enable;
    logic                  irq;
    logic                  waitrequest;
    logic [TGC_DATA_W-1:0] readdata;
  } tgc_state_type;

  tgc_state_type          st;
  tgc_state_type          next_st;
  logic [PW-1:0]          period_timer_count;
  logic                   match_pulse;
  logic                   gate_raw;
  logic                   gate_now;
  logic                   bus_take;
  logic                   wr_take;
  logic                   timer_wr;
  logic                   flag_clr;
  logic                   gate_fall;
  logic [TGC_DATA_W-1:0]  read_word;

  // Byte-lane merge of a write into a register image
  function automatic logic [TGC_DATA_W-1:0] merge_bytes(
    input logic [TGC_DATA_W-1:0] old_val,
    input logic [TGC_DATA_W-1:0] wdata,
    input logic [TGC_BE_W-1:0]   be
  );
    logic [TGC_DATA_W-1:0] res;
    res = old_val;
    for (int i = 0; i < TGC_BE_W; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  ////////////////////////////////////////////////////////////////////////////
  // Period timer instance
  tgc_period_timer #(
    .PW (PW)
  ) u_period (
    .sys_clk_in             (sys_clk_in),
    .rst_n_in               (rst_n_in),
    .run_in                 (st.ctrl.period_run),
    .period_match_value_in  (st.period_match_value),
    .period_timer_count_out (period_timer_count),
    .match_pulse_out        (match_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Gate source select
  always_comb begin
    unique case (st.ctrl.gate_source_select)
      TGC_SRC_PIN:    gate_raw = gate_src_in.gate_pin;
      TGC_SRC_PERIOD: gate_raw = match_pulse;
      TGC_SRC_CMP1:   gate_raw = gate_src_in.comparator_one_output;
      TGC_SRC_CMP2:   gate_raw = gate_src_in.comparator_two_output;
    endcase
  end

  // Polarity one passes the source, zero inverts it
  assign gate_now  = st.ctrl.gate_polarity_select ? gate_raw : ~gate_raw;
  // Falling edge of the gate level
  assign gate_fall = st.gate_level_status && !gate_now;

  assign bus_take = (avs_req_in.read || avs_req_in.write) && !st.waitrequest;
  assign wr_take  = bus_take && avs_req_in.write;
  assign timer_wr = wr_take && avs_req_in.address == TGC_OFF_TIMER_COUNT;
  assign flag_clr = wr_take && avs_req_in.address == TGC_OFF_IRQ_CLEAR
                    && avs_req_in.byteenable[0]
                    && avs_req_in.writedata[TGC_GIF_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Read decode; unmapped and write-only offsets read as zero
  always_comb begin
    read_word = '0;
    unique case (avs_req_in.address)
      TGC_OFF_GATE_CTRL: begin
        read_word[TGC_SSS_LSB +: 2] = st.ctrl.gate_source_select;
        read_word[TGC_GVAL_BIT]     = st.gate_level_status;
        read_word[TGC_POL_BIT]      = st.ctrl.gate_polarity_select;
        read_word[TGC_GE_BIT]       = st.ctrl.gate_enable_bit;
        read_word[TGC_RUN_BIT]      = st.ctrl.timer_run;
        read_word[TGC_PRUN_BIT]     = st.ctrl.period_run;
      end
      TGC_OFF_PERIOD_MATCH: read_word[PW-1:0] = st.period_match_value;
      TGC_OFF_PERIOD_COUNT: read_word[PW-1:0] = period_timer_count;
      TGC_OFF_TIMER_COUNT:  read_word[TW-1:0] = st.timer_count;
      TGC_OFF_COMP_STATUS: begin
        read_word[TGC_CMP1_BIT] = gate_src_in.comparator_one_output;
        read_word[TGC_CMP2_BIT] = gate_src_in.comparator_two_output;
      end
      TGC_OFF_IRQ_STATUS: read_word[TGC_GIF_BIT] = st.gate_event_flag;
      TGC_OFF_IRQ_ENABLE:
        read_word[TGC_GIF_BIT] = st.gate_event_irq_enable;
      default: read_word = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [TGC_DATA_W-1:0] img;
    img     = '0;
    next_st = st;

    // Answer one cycle after the request shows; read data is caught then
    next_st.waitrequest = 1'b1;
    if ((avs_req_in.read || avs_req_in.write) && st.waitrequest) begin
      next_st.waitrequest = 1'b0;
      next_st.readdata    = avs_req_in.read ? read_word : '0;
    end

    if (st.ctrl.timer_run && (!st.ctrl.gate_enable_bit || gate_now)) begin
      next_st.timer_count = TW'(st.timer_count + 1'b1);
    end

    if (wr_take) begin
      unique case (avs_req_in.address)
        TGC_OFF_GATE_CTRL: begin
          img = merge_bytes(read_word, avs_req_in.writedata,
                            avs_req_in.byteenable);
          next_st.ctrl.gate_source_select   = img[TGC_SSS_LSB +: 2];
          next_st.ctrl.gate_polarity_select = img[TGC_POL_BIT];
          next_st.ctrl.gate_enable_bit      = img[TGC_GE_BIT];
          next_st.ctrl.timer_run            = img[TGC_RUN_BIT];
          next_st.ctrl.period_run           = img[TGC_PRUN_BIT];
        end
        TGC_OFF_PERIOD_MATCH: begin
          img = merge_bytes(read_word, avs_req_in.writedata,
                            avs_req_in.byteenable);
          next_st.period_match_value = img[PW-1:0];
        end
        // A software write wins over a same-cycle increment
        TGC_OFF_TIMER_COUNT: begin
          img = merge_bytes(read_word, avs_req_in.writedata,
                            avs_req_in.byteenable);
          next_st.timer_count = img[TW-1:0];
        end
        TGC_OFF_IRQ_ENABLE: begin
          if (avs_req_in.byteenable[0]) begin
            next_st.gate_event_irq_enable =
              avs_req_in.writedata[TGC_GIF_BIT];
          end
        end
        default: img = '0;
      endcase
    end

    // Gate level follows the gate whether gating is on or not
    next_st.gate_level_status = gate_now;

    // Only a software clear drops the flag
    if (flag_clr) begin
      next_st.gate_event_flag = 1'b0;
    end
    // Falling edge sets the flag; set beats clear
    if (gate_fall) begin
      next_st.gate_event_flag = 1'b1;
    end

    next_st.irq = next_st.gate_event_flag && next_st.gate_event_irq_enable;
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st.ctrl                  <= '0;
      st.period_match_value    <= PW'(TGC_PERIOD_MATCH_RST);
      st.timer_count           <= TW'(TGC_TIMER_RST);
      st.gate_level_status     <= 1'b0;
      st.gate_event_flag       <= 1'b0;
      st.gate_event_irq_enable <= 1'b0;
      st.irq                   <= 1'b0;
      st.waitrequest           <= 1'b1;
      st.readdata              <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign avs_readdata_out    = st.readdata;
  assign avs_waitrequest_out = st.waitrequest;
  assign gate_level_out      = st.gate_level_status;
  assign irq_out             = st.irq;

  ////////////////////////////////////////////////////////////////////////////
  logic run_gated;
  assign run_gated = st.ctrl.timer_run && st.ctrl.gate_enable_bit
                     && st.ctrl.gate_polarity_select && !timer_wr;

  chk_period_gate_true: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (run_gated && st.ctrl.gate_source_select == TGC_SRC_PERIOD)
    |=> st.timer_count == TW'($past(st.timer_count) + $past(match_pulse)))
    else $error("polarity one period gate counted wrong");

  chk_period_gate_inv: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (st.ctrl.timer_run && st.ctrl.gate_enable_bit && !timer_wr
     && !st.ctrl.gate_polarity_select
     && st.ctrl.gate_source_select == TGC_SRC_PERIOD)
    |=> st.timer_count == TW'($past(st.timer_count) + !$past(match_pulse)))
    else $error("polarity zero period gate counted wrong");

  chk_cmp_one_gate: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (run_gated && st.ctrl.gate_source_select == TGC_SRC_CMP1)
    |=> st.timer_count == TW'($past(st.timer_count)
                         + $past(gate_src_in.comparator_one_output)))
    else $error("comparator one gate counted wrong");

  chk_cmp_two_gate: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (run_gated && st.ctrl.gate_source_select == TGC_SRC_CMP2)
    |=> st.timer_count == TW'($past(st.timer_count)
                         + $past(gate_src_in.comparator_two_output)))
    else $error("comparator two gate counted wrong");

  chk_gate_level_pin: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (st.ctrl.gate_source_select == TGC_SRC_PIN && !timer_wr)
    |=> gate_level_out == ($past(gate_src_in.gate_pin)
                           ~^ $past(st.ctrl.gate_polarity_select)))
    else $error("gate level does not follow pin and polarity");

  chk_fall_sets_flag: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    $fell(st.gate_level_status) |-> st.gate_event_flag)
    else $error("gate falling edge did not set event flag");

  chk_irq_follows_flag: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    irq_out == (st.gate_event_flag && st.gate_event_irq_enable))
    else $error("interrupt level disagrees with flag and enable");

  chk_flag_sticky: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (st.gate_event_flag && !flag_clr) |=> st.gate_event_flag)
    else $error("event flag cleared without software clear");

  chk_bus_answer: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (avs_req_in.read || avs_req_in.write) |-> ##[0:1] !avs_waitrequest_out)
    else $error("bus request not answered within one cycle");

  cov_gate_event: cover property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    !st.ctrl.gate_enable_bit && $rose(st.gate_event_flag));
  cov_irq: cover property (
    @(posedge sys_clk_in) disable iff (!rst_n_in) $rose(irq_out));
  cov_set_and_clear: cover property (
    @(posedge sys_clk_in) disable iff (!rst_n_in) gate_fall && flag_clr);

endmodule : tgc_top

// [tb/tgc_gate_model.sv]
// Behavioural model of the gate pin and the two on-chip comparators
`timescale 1ns/100ps
module tgc_gate_model (
  // Clock and reset
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_n_in,
  // Gate sources toward the block
  output tgc_pkg::tgc_gate_src_type gate_src_out
);
  import tgc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  tgc_gate_src_type levels = '0;

  assign gate_src_out = levels;

  // Levels change just after an edge, like comparators already synchronised
  task automatic set_levels(input logic pin, input logic c1, input logic c2);
    @(posedge sys_clk_in);
    levels <= '{gate_pin: pin, comparator_one_output: c1,
                comparator_two_output: c2};
  endtask : set_levels
endmodule : tgc_gate_model

// [tb/timer_gate_control_test.sv]
// Self-checking bench for the timer gate control block
`timescale 1ns/100ps
module timer_gate_control_test;
  import tgc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  localparam int M = 4;
  logic                  sys_clk_in = 1'b0;
  logic                  rst_n_in   = 1'b0;
  tgc_avs_req_type       avs_req    = '0;
  logic [TGC_DATA_W-1:0] avs_readdata_out;
  logic                  avs_waitrequest_out;
  tgc_gate_src_type      gate_src;
  logic                  gate_level_out;
  logic                  irq_out;
  int                    err_total  = 0;
  int                    checks     = 0;
  logic [1:0]            srcs [3]   = '{TGC_SRC_PIN, TGC_SRC_CMP1, TGC_SRC_CMP2};

  always #2.5 sys_clk_in = ~sys_clk_in;

  tgc_top #(.TW(16), .PW(8)) u_tgc_top (
    .sys_clk_in          (sys_clk_in),
    .rst_n_in            (rst_n_in),
    .avs_req_in          (avs_req),
    .avs_readdata_out    (avs_readdata_out),
    .avs_waitrequest_out (avs_waitrequest_out),
    .gate_src_in         (gate_src),
    .gate_level_out      (gate_level_out),
    .irq_out             (irq_out)
  );

  tgc_gate_model u_tgc_gate_model (
    .sys_clk_in   (sys_clk_in),
    .rst_n_in     (rst_n_in),
    .gate_src_out (gate_src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Request held until the edge that samples waitrequest low; a hung
  // slave is caught by the watchdog, not by a local limit
  task automatic bus_xfer(input logic wr, input logic [TGC_ADDR_W-1:0] addr,
      input logic [TGC_DATA_W-1:0] wdat, input logic [TGC_BE_W-1:0] be,
      output logic [TGC_DATA_W-1:0] rdat);
    @(posedge sys_clk_in);
    avs_req <= '{read: !wr, write: wr, address: addr, writedata: wdat,
                 byteenable: be};
    do begin
      @(posedge sys_clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    rdat = avs_readdata_out;
    avs_req <= '0;
  endtask : bus_xfer

  task automatic bus_wr(input logic [TGC_ADDR_W-1:0] addr,
      input logic [TGC_DATA_W-1:0] wdat, input logic [3:0] be = 4'hF);
    logic [TGC_DATA_W-1:0] dummy;
    bus_xfer(1'b1, addr, wdat, be, dummy);
  endtask : bus_wr

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
      input logic [31:0] mask, input string what);
    checks++;
    if ((got & mask) !== (exp & mask)) begin
      err_total++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic cmp_rng(input logic [31:0] got, input int lo, input int hi,
      input string what);
    checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      err_total++;
      $display("mismatch at %0t: %s got %0d", $time, what, got);
    end
  endtask : cmp_rng

  task automatic rc(input logic [TGC_ADDR_W-1:0] addr, input logic [31:0] exp,
      input logic [31:0] mask, input string what);
    logic [TGC_DATA_W-1:0] d;
    bus_xfer(1'b0, addr, '0, 4'hF, d);
    cmp(d, exp, mask, what);
  endtask : rc

  // Counts high cycles of the gate level and back-to-back high pairs
  task automatic count_level(input int cycles, output int highs,
      output int pairs);
    logic prev;
    highs = 0;
    pairs = 0;
    prev  = gate_level_out;
    repeat (cycles) begin
      @(posedge sys_clk_in);
      if (gate_level_out === 1'b1) highs++;
      if (gate_level_out === 1'b1 && prev === 1'b1) pairs++;
      prev = gate_level_out;
    end
  endtask : count_level

  task automatic summarize();
    if (err_total == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////
  // Whole sequence needs a few hundred cycles; this leaves ample margin
  initial begin
    #100000;
    err_total++;
    summarize();
  end

  initial begin
    logic [TGC_DATA_W-1:0] d;
    logic lv, e, c1, c2;
    int hi, pr;
    repeat (8) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    rc(TGC_OFF_GATE_CTRL, 32'h004, 32'h3FF, "ctrl reset");
    rc(TGC_OFF_PERIOD_MATCH, 32'hFF, 32'hFF, "match reset");
    rc(TGC_OFF_PERIOD_COUNT, 32'h00, 32'hFF, "period reset");
    rc(TGC_OFF_TIMER_COUNT, 32'h0, 32'hFFFF, "timer reset");
    rc(TGC_OFF_IRQ_ENABLE, 32'h0, 32'h1, "enable reset");
    rc(TGC_OFF_IRQ_CLEAR, 32'h0, 32'hFFFFFFFF, "clear reads zero");
    // Lane 0 disabled: match value must survive
    bus_wr(TGC_OFF_PERIOD_MATCH, 32'h0, 4'h2);
    rc(TGC_OFF_PERIOD_MATCH, 32'hFF, 32'hFF, "byte lane");
    bus_wr(TGC_OFF_PERIOD_MATCH, 32'(M));
    bus_wr(TGC_OFF_PERIOD_COUNT, 32'hFF);
    rc(TGC_OFF_PERIOD_COUNT, 32'h00, 32'hFF, "read-only count");
    // Other sources driven opposite, so a wrong select shows up
    foreach (srcs[i]) begin
      for (int p = 0; p < 2; p++) begin
        for (int v = 0; v < 2; v++) begin
          lv = v[0];
          e  = p[0] ? lv : !lv;
          c1 = (srcs[i] == TGC_SRC_CMP1) ? lv : !lv;
          c2 = (srcs[i] == TGC_SRC_CMP2) ? lv : !lv;
          u_tgc_gate_model.set_levels((srcs[i] == TGC_SRC_PIN) ? lv : !lv,
                                      c1, c2);
          bus_wr(TGC_OFF_GATE_CTRL, 32'(srcs[i]) | (32'(p) << TGC_POL_BIT));
          repeat (3) @(posedge sys_clk_in);
          cmp(32'(gate_level_out), 32'(e), 32'h1, "gate level");
          rc(TGC_OFF_GATE_CTRL, 32'(e) << 2, 32'h4, "level bit");
          rc(TGC_OFF_COMP_STATUS, (32'(c2) << 6) | (32'(c1) << 5), 32'h60,
             "comp status");
        end
      end
    end
    // Gate event on a falling level with gating off
    u_tgc_gate_model.set_levels(1'b1, 1'b0, 1'b0);
    bus_wr(TGC_OFF_GATE_CTRL, 32'h040);
    repeat (3) @(posedge sys_clk_in);
    bus_wr(TGC_OFF_IRQ_CLEAR, 32'h1);
    rc(TGC_OFF_IRQ_STATUS, 32'h0, 32'h1, "flag cleared");
    u_tgc_gate_model.set_levels(1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge sys_clk_in);
    rc(TGC_OFF_IRQ_STATUS, 32'h1, 32'h1, "flag on fall");
    cmp(32'(irq_out), 32'h0, 32'h1, "irq masked");
    bus_wr(TGC_OFF_IRQ_ENABLE, 32'h1);
    repeat (2) @(posedge sys_clk_in);
    cmp(32'(irq_out), 32'h1, 32'h1, "irq raised");
    rc(TGC_OFF_IRQ_STATUS, 32'h1, 32'h1, "flag sticky");
    bus_wr(TGC_OFF_IRQ_CLEAR, 32'h1);
    u_tgc_gate_model.set_levels(1'b1, 1'b0, 1'b0);
    repeat (3) @(posedge sys_clk_in);
    cmp(32'(irq_out), 32'h0, 32'h1, "irq cleared");
    rc(TGC_OFF_IRQ_STATUS, 32'h0, 32'h1, "no flag on rise");
    // Period match pulse: one high cycle in every M+1
    bus_wr(TGC_OFF_GATE_CTRL, 32'h241);
    repeat (10) @(posedge sys_clk_in);
    count_level(8 * (M + 1), hi, pr);
    cmp(32'(hi), 32'h8, 32'hFF, "pulse count");
    cmp(32'(pr), 32'h0, 32'hFF, "pulse width");
    bus_wr(TGC_OFF_GATE_CTRL, 32'h201);
    repeat (10) @(posedge sys_clk_in);
    count_level(8 * (M + 1), hi, pr);
    cmp(32'(hi), 32'(8 * M), 32'hFF, "inverted pulse");
    bus_wr(TGC_OFF_TIMER_COUNT, 32'h0);
    bus_wr(TGC_OFF_GATE_CTRL, 32'h3C1);
    repeat (50) @(posedge sys_clk_in);
    bus_wr(TGC_OFF_GATE_CTRL, 32'h2C1);
    bus_xfer(1'b0, TGC_OFF_TIMER_COUNT, '0, 4'hF, d);
    cmp_rng(d, 9, 12, "timer pol one");
    bus_wr(TGC_OFF_TIMER_COUNT, 32'h0);
    bus_wr(TGC_OFF_GATE_CTRL, 32'h381);
    repeat (50) @(posedge sys_clk_in);
    bus_wr(TGC_OFF_GATE_CTRL, 32'h281);
    bus_xfer(1'b0, TGC_OFF_TIMER_COUNT, '0, 4'hF, d);
    cmp_rng(d, 40, 45, "timer pol zero");
    bus_wr(TGC_OFF_GATE_CTRL, 32'h0);
    bus_xfer(1'b0, TGC_OFF_PERIOD_COUNT, '0, 4'hF, d);
    cmp_rng(d, 0, M, "period wraps");
    // Comparator one gating the timer
    u_tgc_gate_model.set_levels(1'b0, 1'b0, 1'b1);
    bus_wr(TGC_OFF_TIMER_COUNT, 32'h0);
    bus_wr(TGC_OFF_GATE_CTRL, 32'h1C2);
    repeat (20) @(posedge sys_clk_in);
    rc(TGC_OFF_TIMER_COUNT, 32'h0, 32'hFFFF, "gate closed");
    u_tgc_gate_model.set_levels(1'b0, 1'b1, 1'b0);
    repeat (20) @(posedge sys_clk_in);
    bus_wr(TGC_OFF_GATE_CTRL, 32'h0C2);
    bus_xfer(1'b0, TGC_OFF_TIMER_COUNT, '0, 4'hF, d);
    cmp_rng(d, 20, 26, "gate open");
    bus_wr(TGC_OFF_COMP_STATUS, 32'h0);
    rc(TGC_OFF_COMP_STATUS, 32'h20, 32'h60, "read-only comp");
    summarize();
  end
endmodule : timer_gate_control_test
